/* File: verilog/cap_unit.sv */
/*
 * configuration access port unit: key port, pointer port, value port, base relocation.
 * assumes one-cycle io_wr/io_rd strobes from host-bus logic on clk, and an
 * asynchronous strap pin that is sampled after reset release.
 */
`timescale 1ns/10ps
`default_nettype none
module cap_unit (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        shared_strap_pin,
   input  wire logic [15:0] io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   output logic      [7:0]  io_rdata,
   output logic             io_ack,
   output logic             cfg_active,
   output logic             base_valid,
   output logic      [15:0] base_addr
);

   // --------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------
   cap_pkg::cap_top_s r_reg;
   cap_pkg::cap_top_s r_next;

   logic [15:0] cur_base;
   logic        hit_key;
   logic        hit_val;
   logic        in_cfg;
   logic        idx_ok;
   logic        idx_own;
   logic        val_wr;
   logic        cr_wr_en;
   logic [7:0]  cr_rd;
   logic [7:0]  val_rd;

   assign cur_base = {r_reg.base_hi, r_reg.base_lo};
   assign in_cfg   = (r_reg.st == cap_pkg::ST_CFG);
   // decode follows the live base registers, so a relocation acts on the next cycle
   assign hit_key  = r_reg.cap_done && (io_addr == cur_base);
   assign hit_val  = r_reg.cap_done && (io_addr == cur_base + cap_pkg::DATA_OFS);
   assign idx_ok   = (r_reg.index <= cap_pkg::IDX_MAX);
   assign idx_own  = (r_reg.index == cap_pkg::IDX_BASE_LO) || (r_reg.index == cap_pkg::IDX_BASE_HI);
   assign val_wr   = io_wr && hit_val && in_cfg;
   assign cr_wr_en = val_wr && idx_ok && !idx_own;

   cap_cfg_regs u_regs (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (cr_wr_en),
      .wr_idx  (r_reg.index[cap_pkg::IDX_W-1:0]),
      .wr_data (io_wdata),
      .rd_idx  (r_reg.index[cap_pkg::IDX_W-1:0]),
      .rd_data (cr_rd)
   );

   always_comb begin
      if (r_reg.index == cap_pkg::IDX_BASE_LO) begin
         val_rd = r_reg.base_lo;
      end else if (r_reg.index == cap_pkg::IDX_BASE_HI) begin
         val_rd = r_reg.base_hi;
      end else if (idx_ok) begin
         val_rd = cr_rd;
      end else begin
         val_rd = cap_pkg::RDATA_IDLE;
      end
   end

   // --------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------
   always_comb begin
      r_next            = r_reg;
      r_next.strap_sync = {r_reg.strap_sync[0], shared_strap_pin};
      r_next.ack        = 1'b0;
      r_next.rdata      = cap_pkg::RDATA_IDLE;
      if (!r_reg.cap_done) begin
         // ports stay dark until the synchronised strap has been taken
         if (r_reg.cap_cnt == cap_pkg::CAP_WAIT) begin
            r_next.cap_done  = 1'b1;
            r_next.strap_val = r_reg.strap_sync[1];
            if (r_reg.strap_sync[1]) begin
               {r_next.base_hi, r_next.base_lo} = cap_pkg::BASE_STRAP1;
            end else begin
               {r_next.base_hi, r_next.base_lo} = cap_pkg::BASE_STRAP0;
            end
         end else begin
            r_next.cap_cnt = r_reg.cap_cnt + 2'h1;
         end
      end else if (io_wr && hit_key) begin
         r_next.ack = 1'b1;
         case (r_reg.st)
            cap_pkg::ST_RUN: begin
               // any other byte is acked but changes no state
               if (io_wdata == cap_pkg::KEY_ENTER) begin
                  r_next.st = cap_pkg::ST_CFG;
               end
            end
            cap_pkg::ST_CFG: begin
               if (io_wdata == cap_pkg::KEY_EXIT) begin
                  r_next.st = cap_pkg::ST_RUN;
               end else begin
                  r_next.index = io_wdata;
               end
            end
            default: begin
               r_next.st = cap_pkg::ST_RUN;
            end
         endcase
      end else if (val_wr) begin
         r_next.ack = 1'b1;
         if (r_reg.index == cap_pkg::IDX_BASE_LO) begin
            r_next.base_lo = io_wdata;
         end else if (r_reg.index == cap_pkg::IDX_BASE_HI) begin
            r_next.base_hi = io_wdata;
         end
      end else if (io_rd && hit_key && in_cfg) begin
         r_next.ack   = 1'b1;
         r_next.rdata = r_reg.index;
      end else if (io_rd && hit_val && in_cfg) begin
         r_next.ack   = 1'b1;
         r_next.rdata = val_rd;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // no stall or hold output exists: config state never gates other units
   assign io_rdata   = r_reg.rdata;
   assign io_ack     = r_reg.ack;
   assign cfg_active = r_reg.st;
   assign base_valid = r_reg.cap_done;
   assign base_addr  = cur_base;

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------
   property p_strap_base;
      @(posedge clk) disable iff (!rst_n)
      $rose(r_reg.cap_done) |-> (base_addr == (r_reg.strap_val ? cap_pkg::BASE_STRAP1 : cap_pkg::BASE_STRAP0));
   endproperty
   a_strap_base: assert property (p_strap_base) else $error("power-up base does not match strap");

   property p_strap_hold;
      @(posedge clk) disable iff (!rst_n)
      r_reg.cap_done |=> $stable(r_reg.strap_val) && r_reg.cap_done;
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("captured strap changed");

   property p_reloc;
      @(posedge clk) disable iff (!rst_n)
      (val_wr && r_reg.index == cap_pkg::IDX_BASE_LO) |=>
      (base_addr[7:0] == $past(io_wdata)) && (base_addr[15:8] == $past(base_addr[15:8]));
   endproperty
   a_reloc: assert property (p_reloc) else $error("base low write not applied to decode");

   property p_run_silent;
      @(posedge clk) disable iff (!rst_n)
      (io_rd && !io_wr && !in_cfg) |=> !io_ack && (io_rdata == cap_pkg::RDATA_IDLE);
   endproperty
   a_run_silent: assert property (p_run_silent) else $error("port answered in run state");

   property p_ptr_read;
      @(posedge clk) disable iff (!rst_n)
      (io_rd && !io_wr && hit_key && in_cfg) |=> io_ack && (io_rdata == $past(r_reg.index));
   endproperty
   a_ptr_read: assert property (p_ptr_read) else $error("pointer read did not return index");

   property p_reset_run;
      @(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> !cfg_active && !base_valid;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("not in run state after reset");

   property p_enter;
      @(posedge clk) disable iff (!rst_n)
      (hit_key && io_wr && !in_cfg && io_wdata == cap_pkg::KEY_ENTER) |=> cfg_active && io_ack;
   endproperty
   a_enter: assert property (p_enter) else $error("entry key did not enter config state");

   property p_stay;
      @(posedge clk) disable iff (!rst_n)
      (in_cfg && !(io_wr && hit_key && io_wdata == cap_pkg::KEY_EXIT)) |=> cfg_active;
   endproperty
   a_stay: assert property (p_stay) else $error("config state dropped without exit key");

   property p_exit;
      @(posedge clk) disable iff (!rst_n)
      (hit_key && io_wr && in_cfg && io_wdata == cap_pkg::KEY_EXIT) |=> !cfg_active && io_ack;
   endproperty
   a_exit: assert property (p_exit) else $error("exit key did not leave config state");

   property p_run_junk;
      @(posedge clk) disable iff (!rst_n)
      (hit_key && io_wr && !in_cfg && io_wdata != cap_pkg::KEY_ENTER) |=> !cfg_active && $stable(r_reg.index);
   endproperty
   a_run_junk: assert property (p_run_junk) else $error("non-key byte changed run state");

   property p_index_hold;
      @(posedge clk) disable iff (!rst_n)
      !(io_wr && hit_key && in_cfg) |=> $stable(r_reg.index);
   endproperty
   a_index_hold: assert property (p_index_hold) else $error("select latch changed without write");

   property p_val_rw;
      @(posedge clk) disable iff (!rst_n)
      (cr_wr_en ##1 (io_rd && !io_wr && hit_val && in_cfg && $stable(r_reg.index)))
      |=> io_ack && (io_rdata == $past(io_wdata, 2));
   endproperty
   a_val_rw: assert property (p_val_rw) else $error("value port read-back mismatch");

endmodule : cap_unit
`default_nettype wire

/* File: verilog/cap_pkg.sv */
/*
 * constants and types shared by the configuration access port unit.
 * assumes a single host-bus clock and 8-bit host i/o cycles.
 */
// Notes on behaviour
// - strap pin level is caught at reset release and picks the power-up base.
// - strap 0 puts the ports at 0x02E, strap 1 at 0x04E.
// - writing the two base registers moves the ports to the new address.
// - value port (pointer plus one) answers only in config state; the pointer port also acks key writes in run state.
// - pointer port reads return the index only while in config state.
// - after reset the unit is in run state with no register access.
// - key byte 55h on the key port enters config state.
// - host writes an index 00..39h, then reads or writes via the value port.
// - config state persists over any number of accesses until exit.
// - key byte aah on the key port leaves config state and blocks access.
// - other units keep running while config state is active.
package cap_pkg;

   // --------------------------------------------------------------------
   // keys, index space, addresses
   // --------------------------------------------------------------------
   localparam logic [7:0]  KEY_ENTER   = 8'h55;
   localparam logic [7:0]  KEY_EXIT    = 8'hAA;
   localparam logic [7:0]  IDX_MAX     = 8'h39;
   localparam logic [7:0]  IDX_BASE_LO = 8'h12;
   localparam logic [7:0]  IDX_BASE_HI = 8'h13;
   localparam logic [15:0] BASE_STRAP0 = 16'h002E;
   localparam logic [15:0] BASE_STRAP1 = 16'h004E;
   localparam logic [15:0] DATA_OFS    = 16'h0001;
   localparam logic [7:0]  CR_RESET    = 8'h00;
   localparam logic [7:0]  RDATA_IDLE  = 8'h00;
   localparam int          NUM_CR      = 58;
   localparam int          IDX_W       = 6;
   // edges after reset release before the synchronised strap is valid
   localparam logic [1:0]  CAP_WAIT    = 2'h2;

   // --------------------------------------------------------------------
   // types
   // --------------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_CFG = 1'b1
   } cap_state_e;

   typedef struct packed {
      cap_state_e  st;
      logic [1:0]  strap_sync;
      logic [1:0]  cap_cnt;
      logic        cap_done;
      logic        strap_val;
      logic [7:0]  index;
      logic [7:0]  base_lo;
      logic [7:0]  base_hi;
      logic [7:0]  rdata;
      logic        ack;
   } cap_top_s;

   typedef struct packed {
      logic [NUM_CR-1:0][7:0] cr;
   } cap_regs_s;

endpackage : cap_pkg

/* File: verilog/cap_cfg_regs.sv */
/*
 * plain read/write configuration register array, indexed 00..39h.
 * assumes the caller filters out-of-range indexes and registers kept elsewhere.
 */
`timescale 1ns/10ps
`default_nettype none
module cap_cfg_regs (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    wr_en,
   input  wire logic [cap_pkg::IDX_W-1:0] wr_idx,
   input  wire logic [7:0]              wr_data,
   input  wire logic [cap_pkg::IDX_W-1:0] rd_idx,
   output logic      [7:0]              rd_data
);

   cap_pkg::cap_regs_s r_reg;
   cap_pkg::cap_regs_s r_next;

   always_comb begin
      r_next = r_reg;
      if (wr_en) begin
         r_next.cr[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= {cap_pkg::NUM_CR{cap_pkg::CR_RESET}};
      end else begin
         r_reg <= r_next;
      end
   end

   // read is combinational; the top registers it before it leaves the block
   assign rd_data = r_reg.cr[rd_idx];

endmodule : cap_cfg_regs
`default_nettype wire

/* File: verification/cap_host_model.sv */
/*
 * host side model: issues single 8-bit i/o read or write cycles to the unit.
 * assumes the unit takes a one-cycle strobe and holds ack for one cycle from the taking edge.
 */
`timescale 1ns/10ps
`default_nettype none
module cap_host_model (
   input  wire logic        clk,
   output var  logic [15:0] io_addr,
   output var  logic [7:0]  io_wdata,
   output var  logic        io_wr,
   output var  logic        io_rd,
   input  wire logic [7:0]  io_rdata,
   input  wire logic        io_ack
);
   initial begin
      io_addr  = 16'h0000;
      io_wdata = 8'h00;
      io_wr    = 1'h0;
      io_rd    = 1'h0;
   end

   // ---------------------------------------------------------------
   // one i/o cycle
   // ---------------------------------------------------------------
   // key, index and value bytes all ride this cycle; the caller orders them
   task automatic cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic ack, output logic [7:0] rd);
      @(posedge clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= wr;
      io_rd    <= ~wr;
      @(posedge clk);
      io_wr    <= 1'h0;
      io_rd    <= 1'h0;
      // released lines must not keep the last value, or a stale decode could pass
      io_addr  <= ~a;
      io_wdata <= ~d;
      // the answer stands from this edge to the next; take it mid-cycle where it is settled
      @(negedge clk);
      ack = io_ack;
      rd  = io_rdata;
   endtask : cycle

   // write then read of one port on consecutive edges, the tightest legal spacing
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d,
                        output logic ack, output logic [7:0] rd);
      @(posedge clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'h1;
      io_rd    <= 1'h0;
      @(posedge clk);
      io_wr    <= 1'h0;
      io_rd    <= 1'h1;
      @(posedge clk);
      io_rd    <= 1'h0;
      io_addr  <= ~a;
      io_wdata <= ~d;
      @(negedge clk);
      ack = io_ack;
      rd  = io_rdata;
   endtask : wr_rd
endmodule : cap_host_model
`default_nettype wire

/* File: verification/tb_config_access_port_unit.sv */
/*
 * self-checking bench for the configuration access port unit.
 * assumes the host model drives all i/o strobes; strap and reset come from here.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_config_access_port_unit;
   logic        clk;
   logic        rst_n;
   logic        shared_strap_pin;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata;
   logic        io_wr;
   logic        io_rd;
   logic [7:0]  io_rdata;
   logic        io_ack;
   logic        cfg_active;
   logic        base_valid;
   logic [15:0] base_addr;
   int          num_errors;
   int          n_compared;
   logic [34:0] r;
   logic        b2b_ack;
   logic [7:0]  b2b_rd;
   // row: write, address, data, expected ack, expected read byte, expected state after
   logic [34:0] rows [0:21] = '{
      {1'h0, 16'h002E, 8'h00, 1'h0, 8'h00, 1'h0}, {1'h1, 16'h002F, 8'h11, 1'h0, 8'h00, 1'h0},
      {1'h0, 16'h002F, 8'h00, 1'h0, 8'h00, 1'h0}, {1'h1, 16'h002E, 8'h12, 1'h1, 8'h00, 1'h0},
      {1'h1, 16'h0030, 8'h55, 1'h0, 8'h00, 1'h0}, {1'h1, 16'h002E, 8'h55, 1'h1, 8'h00, 1'h1},
      {1'h0, 16'h002E, 8'h00, 1'h1, 8'h00, 1'h1}, {1'h1, 16'h002E, 8'h05, 1'h1, 8'h00, 1'h1},
      {1'h0, 16'h002E, 8'h00, 1'h1, 8'h05, 1'h1}, {1'h1, 16'h002F, 8'h3F, 1'h1, 8'h00, 1'h1},
      {1'h0, 16'h002F, 8'h00, 1'h1, 8'h3F, 1'h1}, {1'h1, 16'h002E, 8'h39, 1'h1, 8'h00, 1'h1},
      {1'h1, 16'h002F, 8'hA5, 1'h1, 8'h00, 1'h1}, {1'h0, 16'h002F, 8'h00, 1'h1, 8'hA5, 1'h1},
      {1'h1, 16'h002E, 8'h3A, 1'h1, 8'h00, 1'h1}, {1'h1, 16'h002F, 8'h77, 1'h1, 8'h00, 1'h1},
      {1'h0, 16'h002F, 8'h00, 1'h1, 8'h00, 1'h1}, {1'h1, 16'h002E, 8'h05, 1'h1, 8'h00, 1'h1},
      {1'h0, 16'h002F, 8'h00, 1'h1, 8'h3F, 1'h1}, {1'h1, 16'h002E, 8'hAA, 1'h1, 8'h00, 1'h0},
      {1'h0, 16'h002F, 8'h00, 1'h0, 8'h00, 1'h0}, {1'h0, 16'h002E, 8'h00, 1'h0, 8'h00, 1'h0}};

   cap_unit dut (
      .clk              (clk),
      .rst_n            (rst_n),
      .shared_strap_pin (shared_strap_pin),
      .io_addr          (io_addr),
      .io_wdata         (io_wdata),
      .io_wr            (io_wr),
      .io_rd            (io_rd),
      .io_rdata         (io_rdata),
      .io_ack           (io_ack),
      .cfg_active       (cfg_active),
      .base_valid       (base_valid),
      .base_addr        (base_addr)
   );

   cap_host_model host (
      .clk      (clk),
      .io_addr  (io_addr),
      .io_wdata (io_wdata),
      .io_wr    (io_wr),
      .io_rd    (io_rd),
      .io_rdata (io_rdata),
      .io_ack   (io_ack)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input logic ea, input logic [7:0] er);
      logic       ack;
      logic [7:0] rd;
      host.cycle(wr, a, d, ack, rd);
      chk({15'h0000, ack}, {15'h0000, ea});
      chk({8'h00, rd}, {8'h00, er});
   endtask : acc

   // strap held steady well past the sync window after release
   task automatic do_reset(input logic s);
      @(posedge clk);
      shared_strap_pin <= s;
      rst_n            <= 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      // two edges after release the synchronised strap is not yet taken, so the ports stay dark
      repeat (3) @(negedge clk);
      chk({15'h0000, base_valid}, 16'h0000);
      chk({15'h0000, cfg_active}, 16'h0000);
      repeat (2) @(negedge clk);
   endtask : do_reset

   task automatic final_report();
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // ---------------------------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      final_report();
   end

   initial begin
      rst_n            = 1'h0;
      shared_strap_pin = 1'h0;
      do_reset(1'h0);
      chk(base_addr, cap_pkg::BASE_STRAP0);
      chk({15'h0000, base_valid}, 16'h0001);
      chk({15'h0000, cfg_active}, 16'h0000);
      for (int i = 0; i < 22; i++) begin
         r = rows[i];
         acc(r[34], r[33:18], r[17:10], r[9], r[8:1]);
         chk({15'h0000, cfg_active}, {15'h0000, r[0]});
      end
      // move the ports low byte first, then high byte, using the moved address
      acc(1'h1, 16'h002E, 8'h55, 1'h1, 8'h00);
      acc(1'h1, 16'h002E, 8'h12, 1'h1, 8'h00);
      acc(1'h1, 16'h002F, 8'h60, 1'h1, 8'h00);
      chk(base_addr, 16'h0060);
      acc(1'h1, 16'h002E, 8'h13, 1'h0, 8'h00);
      acc(1'h1, 16'h0060, 8'h13, 1'h1, 8'h00);
      acc(1'h1, 16'h0061, 8'h01, 1'h1, 8'h00);
      chk(base_addr, 16'h0160);
      acc(1'h0, 16'h0160, 8'h00, 1'h1, 8'h13);
      acc(1'h1, 16'h0160, 8'hAA, 1'h1, 8'h00);
      // second reset in mid-run with the other strap level
      do_reset(1'h1);
      chk(base_addr, cap_pkg::BASE_STRAP1);
      acc(1'h1, 16'h002E, 8'h55, 1'h0, 8'h00);
      acc(1'h1, 16'h004E, 8'h55, 1'h1, 8'h00);
      acc(1'h0, 16'h004E, 8'h00, 1'h1, 8'h00);
      acc(1'h1, 16'h004E, 8'h12, 1'h1, 8'h00);
      acc(1'h0, 16'h004F, 8'h00, 1'h1, 8'h4E);
      acc(1'h1, 16'h004E, 8'h20, 1'h1, 8'h00);
      host.wr_rd(16'h004F, 8'h5C, b2b_ack, b2b_rd);
      chk({15'h0000, b2b_ack}, 16'h0001);
      chk({8'h00, b2b_rd}, 16'h005C);
      final_report();
   end
endmodule : tb_config_access_port_unit
`default_nettype wire
